//--- hw/fow_pkg.sv
package fow_pkg;
  // Register addresses on the register-access port
  localparam logic [7:0]  FOW_ADDR_LOW      = 8'h00;
  localparam logic [7:0]  FOW_ADDR_HIGH     = 8'h01;
  // Field layout
  localparam int          FOW_WORD_W        = 26;
  localparam int          FOW_LOW_W         = 16;
  localparam int          FOW_HIGH_W        = 10;
  localparam int          FOW_OE_BIT        = 10;
  // Reset values
  localparam logic [15:0] FOW_LOW_RST       = 16'h0000;
  localparam logic [9:0]  FOW_HIGH_RST      = 10'h000;
  localparam logic        FOW_OE_RST        = 1'b0;
  localparam logic [15:0] FOW_RDATA_RST     = 16'h0000;

  // One register access from the serial slave engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } fow_req_t;

  // Read answer back to the serial slave engine
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } fow_rsp_t;
endpackage : fow_pkg

//--- hw/fow_oe_sel.sv
`timescale 1ns/1ps
module fow_oe_sel (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // Enable sources
  input  wire logic sw_mode_in,
  input  wire logic sw_oe_in,
  input  wire logic pin_oe_in,
  // Registered output-driver enable
  output logic      drv_en_out
);
  import fow_pkg::*;

  // Registered so the top output comes straight from a flip-flop
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drv_en_out <= FOW_OE_RST;
    end else begin
      drv_en_out <= sw_mode_in ? sw_oe_in : pin_oe_in; // see (R9)
    end
  end
endmodule : fow_oe_sel

//--- hw/fow_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Offset bits 15:0 are the read/write low word at address 0x00.
// (R2) Offset bits 25:16 sit in bits 9:0 of register 0x01.
// (R3) The 26-bit offset word is a signed two's-complement value.
// (R4) Reset clears all 26 offset bits, giving nominal frequency.
// (R5) New offset applies only on a high-word write, with stored low word.
// (R6) Master should write low word before high word.
// (R7) Bits 15:11 of 0x01 read zero and ignore writes.
// (R8) Bit 10 of 0x01 is software output enable, reset zero.
// (R9) Software enable acts only in software mode; pin mode ignores it.
// (R10) Master sets bit 10 on high write to keep output enabled.
// (R11) Master must not commit offsets faster than 38 kHz.
// (R12) Low word is staged; full word moves to active in one cycle.
module fow_regs (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  // Register access from the serial slave engine
  input  wire fow_pkg::fow_req_t    req_in,
  output fow_pkg::fow_rsp_t         rsp_out,
  // Output-enable configuration
  input  wire logic                 sw_oe_mode_in,
  input  wire logic                 oe_pin_in,
  // To the oscillator core
  output logic signed [25:0]        freq_offset_word_out,
  output logic                      offset_commit_out,
  output logic                      out_drive_en_out
);
  import fow_pkg::*;

  // Staged low word and stored fields of register 0x01
  logic [FOW_LOW_W-1:0]  offset_low_word_r;
  logic [FOW_LOW_W-1:0]  offset_low_word_nxt;
  logic [FOW_HIGH_W-1:0] offset_high_word_r;
  logic [FOW_HIGH_W-1:0] offset_high_word_nxt;
  logic                  sw_oe_r;
  logic                  sw_oe_nxt;

  // Next values of the registered outputs
  logic [FOW_WORD_W-1:0] active_word_nxt;
  logic                  commit_nxt;
  logic                  rd_valid_nxt;
  logic [FOW_LOW_W-1:0]  rd_data_nxt;

  // Write data fields as the two registers see them
  logic [FOW_LOW_W-1:0]  wr_data;
  logic [FOW_HIGH_W-1:0] wr_high_bits;
  logic                  wr_oe_bit;

  // Decoded strobes for this cycle's access
  logic                  wr_low;
  logic                  wr_high;
  logic                  rd_low;
  logic                  rd_high;

  // True when an access of the given kind hits the given address;
  // one decode for reads and writes keeps both views of the map equal
  function automatic logic hits_reg(
    input fow_req_t   req,
    input logic       is_wr,
    input logic [7:0] addr
  );
    logic kind_ok;
    kind_ok = is_wr ? req.wr : req.rd;
    return kind_ok && (req.addr == addr);
  endfunction : hits_reg

  // Whole offset word from its halves; the top bit of the high half is the sign
  function automatic logic [FOW_WORD_W-1:0] join_word(
    input logic [FOW_HIGH_W-1:0] high,
    input logic [FOW_LOW_W-1:0]  low
  );
    return {high, low}; // see (R3)
  endfunction : join_word

  // Read image of register 0x01; bits 15:11 hold no state, so they read zero
  function automatic logic [FOW_LOW_W-1:0] high_reg_image(
    input logic                  oe,
    input logic [FOW_HIGH_W-1:0] high
  );
    logic [FOW_LOW_W-1:0] img;
    img                 = FOW_RDATA_RST; // see (R7)
    img[FOW_OE_BIT]     = oe;            // see (R8)
    img[FOW_HIGH_W-1:0] = high;          // see (R2)
    return img;
  endfunction : high_reg_image

  // Write data fields split once for the low, high and enable paths
  assign wr_data      = req_in.wdata;
  assign wr_high_bits = req_in.wdata[FOW_HIGH_W-1:0]; // see (R2)
  assign wr_oe_bit    = req_in.wdata[FOW_OE_BIT];     // see (R8)

  // Write decode; other addresses belong to registers outside this block
  assign wr_low  = hits_reg(req_in, 1'b1, FOW_ADDR_LOW);
  assign wr_high = hits_reg(req_in, 1'b1, FOW_ADDR_HIGH);

  // Read decode; the same map as the writes, through the same function
  assign rd_low  = hits_reg(req_in, 1'b0, FOW_ADDR_LOW);
  assign rd_high = hits_reg(req_in, 1'b0, FOW_ADDR_HIGH);

  // A low write only stages the value, so a half-written update never
  // reaches the oscillator core
  always_comb begin
    offset_low_word_nxt = offset_low_word_r;
    if (wr_low) begin
      offset_low_word_nxt = wr_data; // see (R1) see (R12)
    end
  end

  // Low word staging register; reads of 0x00 see it at once, the core only
  // after the next high write
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_low_word_r <= FOW_LOW_RST; // see (R4)
    end else begin
      offset_low_word_r <= offset_low_word_nxt;
    end
  end

  // A high write takes bits 9:0; bits 15:11 are dropped here and never stored
  always_comb begin
    offset_high_word_nxt = offset_high_word_r;
    if (wr_high) begin
      offset_high_word_nxt = wr_high_bits; // see (R2) see (R7)
    end
  end

  // High word register; it always matches bits 25:16 of the active word
  // because both load on the same write
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_high_word_r <= FOW_HIGH_RST; // see (R4)
    end else begin
      offset_high_word_r <= offset_high_word_nxt;
    end
  end

  // Bit 10 of every high write sets or clears the software enable, so a master
  // that wants the output kept on must write it as 1 each time
  always_comb begin
    sw_oe_nxt = sw_oe_r;
    if (wr_high) begin
      sw_oe_nxt = wr_oe_bit; // see (R8)
    end
  end

  // Software enable bit, off after reset so the output starts disabled
  // until software or the pin turns it on
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sw_oe_r <= FOW_OE_RST; // see (R8)
    end else begin
      sw_oe_r <= sw_oe_nxt;
    end
  end

  // The active word moves whole on the high write, pairing the new high bits
  // with the staged low word; the core never sees a mix of old and new halves
  always_comb begin
    active_word_nxt = $unsigned(freq_offset_word_out);
    if (wr_high) begin
      active_word_nxt = join_word(wr_high_bits, offset_low_word_r); // see (R5) see (R12)
    end
  end

  // Active offset register; reset puts the oscillator at nominal frequency
  // with every offset bit clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      freq_offset_word_out <= $signed({FOW_HIGH_RST, FOW_LOW_RST}); // see (R4)
    end else begin
      freq_offset_word_out <= $signed(active_word_nxt);
    end
  end

  // Commit follows every high write; nothing here paces commits, so keeping
  // them slow enough for the core is left to the master
  assign commit_nxt = wr_high; // see (R5)

  // Commit strobe register, high for exactly one cycle per high write
  // so the core can start its frequency step
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offset_commit_out <= 1'b0;
    end else begin
      offset_commit_out <= commit_nxt;
    end
  end

  // Valid follows every read, mapped or not
  assign rd_valid_nxt = req_in.rd; // see (R1)

  // Read data; unmapped addresses and idle cycles return zero, and a read in
  // the same cycle as a write still sees the old value
  always_comb begin
    rd_data_nxt = FOW_RDATA_RST;
    if (rd_low) begin
      rd_data_nxt = offset_low_word_r; // see (R1)
    end else if (rd_high) begin
      rd_data_nxt = high_reg_image(sw_oe_r, offset_high_word_r); // see (R2) see (R7) see (R8)
    end
  end

  // Answer register, one cycle after the request; rdata drops back to zero
  // on the cycle after a read unless another read follows it at once
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_out <= '{valid: 1'b0, rdata: FOW_RDATA_RST};
    end else begin
      rsp_out <= '{valid: rd_valid_nxt, rdata: rd_data_nxt};
    end
  end

  // Output-driver enable source selection; the software bit is still stored
  // in pin mode and takes over only when software mode is selected
  fow_oe_sel u_oe_sel (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .sw_mode_in (sw_oe_mode_in),
    .sw_oe_in   (sw_oe_r),
    .pin_oe_in  (oe_pin_in),
    .drv_en_out (out_drive_en_out)
  );
endmodule : fow_regs

//--- sim/fow_regs_asserts.sv
`timescale 1ns/1ps
module fow_regs_asserts (
  // Clock, reset and access port
  input wire logic               clk_sys_in,
  input wire logic               rst_b_in,
  input wire fow_pkg::fow_req_t  req_in,
  input wire fow_pkg::fow_rsp_t  rsp_out,
  // Enable control and core side
  input wire logic               sw_oe_mode_in,
  input wire logic               oe_pin_in,
  input wire logic signed [25:0] freq_offset_word_out,
  input wire logic               offset_commit_out,
  input wire logic               out_drive_en_out
);
  import fow_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // High-word write is the only commit trigger
  wire hw = req_in.wr && req_in.addr == FOW_ADDR_HIGH;
  AST_COMMIT: assert property (hw |=> offset_commit_out) else $error("no commit");
  AST_NO_COMMIT: assert property (!hw |=> !offset_commit_out) else $error("stray commit");
  AST_HIGH: assert property (hw |=> freq_offset_word_out[25:16] == $past(req_in.wdata[9:0]))
    else $error("high bits");
  AST_HOLD: assert property (!offset_commit_out |-> $stable(freq_offset_word_out)) else $error("word moved");
  AST_VALID: assert property (req_in.rd |=> rsp_out.valid) else $error("no valid");
  AST_RSV: assert property (req_in.rd && req_in.addr == FOW_ADDR_HIGH |=> rsp_out.rdata[15:11] == 5'h00)
    else $error("unused bits");
  AST_IDLE: assert property (!req_in.rd |=> !rsp_out.valid && rsp_out.rdata == 16'h0000) else $error("idle rsp");
  // Pin mode must ignore the software bit and track the pin one cycle late
  AST_PIN: assert property (!sw_oe_mode_in ##1 !sw_oe_mode_in |-> out_drive_en_out == $past(oe_pin_in))
    else $error("pin enable");
  cover property (hw);
  cover property (req_in.rd ##1 rsp_out.valid);
  cover property (!sw_oe_mode_in && out_drive_en_out);
endmodule : fow_regs_asserts
bind fow_regs fow_regs_asserts chk (.*);

//--- sim/fow_host.sv
`timescale 1ns/1ps
module fow_host (
  // Clock and request out
  input  wire logic       clk_sys_in,
  output fow_pkg::fow_req_t req_out
);
  import fow_pkg::*;
  initial req_out = '0;
  // One-cycle access; commits are paced since the core cannot follow faster updates
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in) req_out <= '{w, !w, a, d};
    @(posedge clk_sys_in) req_out <= '0;
    if (w && a == FOW_ADDR_HIGH) repeat (5264) @(posedge clk_sys_in);
  endtask : acc
endmodule : fow_host

//--- sim/fow_regs_tb.sv
`timescale 1ns/1ps
module fow_regs_tb;
  import fow_pkg::*;
  logic clk_sys_in = 0, rst_b_in = 0, sw_oe_mode_in = 1, oe_pin_in = 0, commit, drv;
  fow_req_t req;
  fow_rsp_t rsp;
  logic signed [25:0] word;
  int err_total = 0, total_checks = 0, cyc = 0, n_commit = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  fow_host host (.clk_sys_in(clk_sys_in), .req_out(req));
  fow_regs dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_in(req), .rsp_out(rsp),
    .sw_oe_mode_in(sw_oe_mode_in), .oe_pin_in(oe_pin_in), .freq_offset_word_out(word),
    .offset_commit_out(commit), .out_drive_en_out(drv));
  // Compare and report
  task automatic chk(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Read and judge the answer one cycle later
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.acc(0, a, 16'h0000);
    #1 chk(rsp.valid, 1); chk(rsp.rdata, e);
  endtask : rd
  task automatic t_reset;
    chk(word, 0); chk(drv, 0); rd(FOW_ADDR_LOW, 16'h0000); rd(FOW_ADDR_HIGH, 16'h0000);
  endtask : t_reset
  // Low word alone must not move the output; unused high bits are dropped
  task automatic t_commit;
    host.acc(1, FOW_ADDR_LOW, 16'hbeef);
    #1 chk(word, 0); chk(commit, 0);
    host.acc(1, FOW_ADDR_HIGH, 16'hffa5);
    #1 chk(word[25:0], 26'h3a5beef); chk(word < 0, 1); chk(drv, 1);
    rd(FOW_ADDR_HIGH, 16'h07a5); rd(FOW_ADDR_LOW, 16'hbeef); rd(8'h05, 16'h0000);
    // Enable bit written as zero must turn the output off in software mode
    host.acc(1, FOW_ADDR_HIGH, 16'h0001);
    #1 chk(drv, 0); chk(word[25:0], 26'h001beef); chk(n_commit, 2);
  endtask : t_commit
  task automatic t_pin;
    @(posedge clk_sys_in) sw_oe_mode_in <= 0;
    host.acc(1, FOW_ADDR_HIGH, 16'h0402);
    #1 chk(drv, 0); chk(word[25:0], 26'h002beef); chk(n_commit, 3);
    @(posedge clk_sys_in) oe_pin_in <= 1;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(drv, 1);
  endtask : t_pin
  // Cycle ceiling well above three paced commits; commit pulses are counted
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (commit === 1'b1) n_commit <= n_commit + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1;
    t_reset();
    t_commit();
    t_pin();
    end_sim();
  end
endmodule : fow_regs_tb
